/* File: tap_map.vh */
// constants for the reduced test access port: instruction codes,
// identification value, controller state codes
// assumes inclusion by the controller, the port logic and the bench
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
`define IR_WIDTH 4
`define INSN_BYPASS 4'hf
`define INSN_IDENT 4'h1
// reset value of the instruction register selects identification
`define INSN_RESET 4'h1
// capture pattern of the instruction register, two low bits 01
`define IR_CAPTURE 4'h1
// identification word, value arbitrary, bit 0 set as the standard wants
`define ID_VALUE 32'h0a5c_3001
`define ID_WIDTH 32
// controller states
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SH_IR 4'hb
`define ST_EX1_IR 4'hc
`define ST_PAUSE_IR 4'hd
`define ST_EX2_IR 4'he
`define ST_UPD_IR 4'hf
`endif

/* File: tap_fsm.v */
// sixteen-state test port controller, advanced by one step per
// rising test clock edge as found by the caller
// assumes mode select is already synchronised and sampled on that edge
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"
module tap_fsm (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire step,
   input wire mode_sel,
   output reg [3:0] state_q
);
   reg [3:0] state_d;

   // next state from the standard transition table
   always @* begin
      state_d = state_q;
      case (state_q)
         `ST_RESET: state_d = mode_sel ? `ST_RESET : `ST_IDLE;
         `ST_IDLE: state_d = mode_sel ? `ST_SEL_DR : `ST_IDLE;
         `ST_SEL_DR: state_d = mode_sel ? `ST_SEL_IR : `ST_CAP_DR;
         `ST_CAP_DR: state_d = mode_sel ? `ST_EX1_DR : `ST_SH_DR;
         `ST_SH_DR: state_d = mode_sel ? `ST_EX1_DR : `ST_SH_DR;
         `ST_EX1_DR: state_d = mode_sel ? `ST_UPD_DR : `ST_PAUSE_DR;
         `ST_PAUSE_DR: state_d = mode_sel ? `ST_EX2_DR : `ST_PAUSE_DR;
         `ST_EX2_DR: state_d = mode_sel ? `ST_UPD_DR : `ST_SH_DR;
         `ST_UPD_DR: state_d = mode_sel ? `ST_SEL_DR : `ST_IDLE;
         `ST_SEL_IR: state_d = mode_sel ? `ST_RESET : `ST_CAP_IR;
         `ST_CAP_IR: state_d = mode_sel ? `ST_EX1_IR : `ST_SH_IR;
         `ST_SH_IR: state_d = mode_sel ? `ST_EX1_IR : `ST_SH_IR;
         `ST_EX1_IR: state_d = mode_sel ? `ST_UPD_IR : `ST_PAUSE_IR;
         `ST_PAUSE_IR: state_d = mode_sel ? `ST_EX2_IR : `ST_PAUSE_IR;
         `ST_EX2_IR: state_d = mode_sel ? `ST_UPD_IR : `ST_SH_IR;
         `ST_UPD_IR: state_d = mode_sel ? `ST_SEL_DR : `ST_IDLE;
         default: state_d = `ST_RESET;
      endcase
   end

   // power-up reset replaces a test reset pin
   always @(posedge clk_sys) begin
      if (rst) begin
         state_q <= `ST_RESET; // R2
      end else if (ce && step) begin
         state_q <= state_d; // R14
      end
   end
endmodule
`default_nettype wire

/* File: tap_port.v */
// reduced boundary-scan test access port: bypass and identification
// assumes the three incoming port pins arrive asynchronously from a host whose
// test clock is much slower than clk_sys; rst is the power-up reset
//
// Function
// R1 - four pins only: clock, mode select, data in, data out; no reset pin
// R2 - power-up reset puts the controller in its test reset state
// R3 - host holds mode select high during normal user operation
// R4 - data in is sampled on each rising test clock edge
// R5 - data out changes on each falling test clock edge while shifting
// R6 - data out is high impedance when nothing is being shifted
// R7 - code 1111 places the one-bit bypass stage between in and out
// R8 - all-ones instruction scan decodes as bypass
// R9 - code 0001 places the identification register between in and out
// R10 - works as one member of a multi-device scan chain
// R11 - port pins dedicated by default; a setting frees them as user I/O
// R12 - while the port is enabled its pins are not user I/O
// R13 - cells behind the port pins stay usable as buried logic
// R14 - four-bit instruction register under the sixteen-state controller
// R15 - unimplemented codes act as bypass
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"
module tap_port (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire port_enable,
   input wire tck_pin, // R1
   input wire tms_pin,
   input wire tdi_pin,
   output reg tdo_out,
   output reg tdo_oe,
   input wire [3:0] user_out,
   input wire [3:0] user_oe,
   output reg [3:0] user_in,
   output reg [3:0] pin_out,
   output reg [3:0] pin_oe,
   output reg [3:0] buried_q,
   input wire [3:0] buried_d,
   output reg [3:0] ir_q,
   output reg test_reset_q
);
   // timing budget, in clk_sys cycles, for one test clock edge:
   // two cycles through the synchroniser, one for the edge finder,
   // then the controller and shift registers act on the next edge.
   // a falling edge reaches the data out pin about four cycles after
   // the pin fell, so the host must keep each test clock phase at
   // three system cycles or more; a faster test clock is not seen.
   // mode select and data in travel through the same two flops as the
   // clock, so they stay aligned with the edge that samples them.
   // the host must keep them steady for the same span after a rise.

   // pin order on the 4-bit user buses: 0 clock, 1 mode, 2 data in, 3 out
   // bit 3 of the synchroniser is spare; data out is never an input
   reg [3:0] sync1_q;
   reg [3:0] sync2_q;
   // sampled test clock from the previous system cycle
   reg tck_prev_q;
   // instruction shift stage and the current instruction
   reg [3:0] ir_shift_q;
   // identification word; bit 0 doubles as the bypass stage
   reg [`ID_WIDTH-1:0] dr_shift_q;
   // bit and enable launched on the last falling test clock edge
   reg shift_bit_q;
   reg shifting_q;
   // synchronised pins and edge strobes
   wire [3:0] state;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire rise;
   wire fall;
   wire sel_id;
   wire [3:0] state_nx;
   reg serial_out;

   // two flops on every incoming pin; first stage feeds only the second
   always @(posedge clk_sys) begin
      if (rst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else if (ce) begin
         sync1_q <= {1'b0, tdi_pin, tms_pin, tck_pin};
         sync2_q <= sync1_q;
      end
   end

   // freed pins behave as plain I/O, dedicated ones hide from the user
   assign tck_s = sync2_q[0] & port_enable;
   assign tms_s = sync2_q[1] | ~port_enable; // R3
   assign tdi_s = sync2_q[2];

   // edge finder on the sampled test clock
   always @(posedge clk_sys) begin
      if (rst) begin
         tck_prev_q <= 1'b0;
      end else if (ce) begin
         tck_prev_q <= tck_s;
      end
   end
   assign rise = tck_s & ~tck_prev_q;
   assign fall = ~tck_s & tck_prev_q;

   tap_fsm u_fsm (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .step(rise),
      .mode_sel(tms_s),
      .state_q(state)
   );

   // identification path only for its own code; others fall to bypass
   assign sel_id = (ir_q == `INSN_IDENT); // R9 R15

   // rising edge: capture, shift in, update (state is the pre-edge one)
   always @(posedge clk_sys) begin
      if (rst) begin
         ir_shift_q <= `IR_CAPTURE;
         dr_shift_q <= {`ID_WIDTH{1'b0}};
         ir_q <= `INSN_RESET; // R14
      end else if (ce && rise) begin
         case (state)
            `ST_RESET: begin
               ir_q <= `INSN_RESET; // R2
            end
            `ST_CAP_IR: begin
               ir_shift_q <= `IR_CAPTURE;
            end
            `ST_SH_IR: begin
               // all-ones input leaves 1111 here, which is bypass
               ir_shift_q <= {tdi_s, ir_shift_q[3:1]}; // R4 R8
            end
            `ST_UPD_IR: begin
               ir_q <= ir_shift_q; // R14
            end
            `ST_CAP_DR: begin
               if (sel_id) begin
                  dr_shift_q <= `ID_VALUE; // R9
               end else begin
                  dr_shift_q <= {`ID_WIDTH{1'b0}}; // R7
               end
            end
            `ST_SH_DR: begin
               if (sel_id) begin
                  dr_shift_q <= {tdi_s, dr_shift_q[`ID_WIDTH-1:1]}; // R9
               end else begin
                  // single stage: one clock of delay through the device
                  dr_shift_q[0] <= tdi_s; // R7 R10
               end
            end
            `ST_IDLE: begin
               // nothing moves between scans
               ir_shift_q <= ir_shift_q;
            end
            `ST_SEL_DR: begin
               // passing state, no register touched
               ir_shift_q <= ir_shift_q;
            end
            `ST_SEL_IR: begin
               // passing state, no register touched
               ir_shift_q <= ir_shift_q;
            end
            `ST_EX1_IR: begin
               // shifted value waits for update or a pause
               ir_shift_q <= ir_shift_q;
            end
            `ST_PAUSE_IR: begin
               // host may stall here as long as it likes
               ir_shift_q <= ir_shift_q;
            end
            `ST_EX2_IR: begin
               // leaves for update or resumes shifting
               ir_shift_q <= ir_shift_q;
            end
            `ST_EX1_DR: begin
               // data path holds its last shifted value
               dr_shift_q <= dr_shift_q;
            end
            `ST_PAUSE_DR: begin
               // data path stalls with the host
               dr_shift_q <= dr_shift_q;
            end
            `ST_EX2_DR: begin
               // leaves for update or resumes shifting
               dr_shift_q <= dr_shift_q;
            end
            `ST_UPD_DR: begin
               // neither bypass nor identification has a parallel stage
               dr_shift_q <= dr_shift_q;
            end
            default: begin
               ir_shift_q <= ir_shift_q;
            end
         endcase
      end
   end

   // bit presented at the serial output this instant
   // chosen from the state after the rise, the one the fall belongs to
   always @* begin
      case (state)
         `ST_SH_IR: begin
            // instruction path while its shift state is current
            serial_out = ir_shift_q[0];
         end
         `ST_SH_DR: begin
            // identification word or the bypass stage
            serial_out = dr_shift_q[0];
         end
         default: begin
            // not driven out; the enable drops on this fall
            serial_out = dr_shift_q[0];
         end
      endcase
   end

   assign state_nx = state;

   // falling edge: drive output while a shift state is current
   always @(posedge clk_sys) begin
      if (rst) begin
         shift_bit_q <= 1'b0;
         shifting_q <= 1'b0;
      end else if (ce && fall) begin
         shift_bit_q <= serial_out; // R5
         shifting_q <= (state_nx == `ST_SH_IR) ||
                       (state_nx == `ST_SH_DR); // R6
      end else if (ce && !port_enable) begin
         shifting_q <= 1'b0;
      end
   end

   // pad muxing: dedicated pins vs user I/O, all outputs registered
   // the extra register costs one cycle on data out, well inside the
   // nearly full test clock the host waits before it samples the next bit.
   // port_enable is a configuration level; toggling it mid-scan
   // releases data out at once and leaves the controller where it was
   always @(posedge clk_sys) begin
      if (rst) begin
         tdo_out <= 1'b0;
         tdo_oe <= 1'b0;
         user_in <= 4'h0;
         pin_out <= 4'h0;
         pin_oe <= 4'h0;
         buried_q <= 4'h0;
         test_reset_q <= 1'b1;
      end else if (ce) begin
         // macrocells behind the pins keep working as buried logic
         buried_q <= buried_d; // R13
         test_reset_q <= (state == `ST_RESET);
         if (port_enable) begin
            tdo_out <= shift_bit_q; // R5
            tdo_oe <= shifting_q; // R6
            user_in <= 4'h0; // R12
            pin_out <= 4'h0;
            pin_oe <= 4'h0; // R12
         end else begin
            // freed pins: user data, port output stays released
            tdo_out <= 1'b0; // R11
            tdo_oe <= 1'b0;
            user_in <= {1'b0, sync2_q[2:0]}; // R11
            pin_out <= user_out;
            pin_oe <= user_oe;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tap_port_sva.sv */
// checker for the reduced test port, watching its top ports only
// assumes a bind onto tap_port and a free-running clk_sys
`timescale 1ns/1ps
`default_nettype none
module tap_port_sva (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic port_enable,
   input wire logic tck_pin,
   input wire logic tdo_out,
   input wire logic tdo_oe,
   input wire logic [3:0] user_out,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] buried_q,
   input wire logic [3:0] buried_d,
   input wire logic [3:0] ir_q,
   input wire logic test_reset_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // pin edges reach the logic a few cycles late through the synchroniser
   property p_rst; $fell(rst) |-> test_reset_q && ir_q == 4'h1 && !tdo_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_tdo; port_enable && $changed(tdo_out) |-> !$past(tck_pin, 3);
   endproperty
   a_tdo: assert property (p_tdo) else $error("tdo moved off fall");
   property p_oe; $rose(tdo_oe) |-> !$past(tck_pin, 3); endproperty
   a_oe: assert property (p_oe) else $error("drive began off fall");
   property p_idle; test_reset_q |-> !tdo_oe; endproperty
   a_idle: assert property (p_idle) else $error("tdo driven in reset");
   property p_ir; $changed(ir_q) |-> $past(tck_pin, 2); endproperty
   a_ir: assert property (p_ir) else $error("ir moved off rise");
   property p_free; !port_enable |=> pin_out == $past(user_out);
   endproperty
   a_free: assert property (p_free) else $error("user pin lost");
   property p_ded; port_enable |-> pin_out == 4'h0; endproperty
   a_ded: assert property (p_ded) else $error("test pin as user");
   property p_bur; !$past(rst) |-> buried_q == $past(buried_d);
   endproperty
   a_bur: assert property (p_bur) else $error("buried path");
   c_oe: cover property ($rose(tdo_oe));
   c_byp: cover property (ir_q == 4'hf);
   c_free: cover property (!port_enable);
endmodule
`default_nettype wire

/* File: tap_host.sv */
// external scan host: drives test clock, mode select and data in
// assumes a board pull-up on data out; test clock idles low, 400 ns
`timescale 1ns/1ps
`default_nettype none
module tap_host (
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input wire logic tdo_out,
   input wire logic tdo_oe
);
   // a released data out reads high through the pull-up
   wire tdo = tdo_oe ? tdo_out : 1'b1;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one clock; sample late in high phase, well after the fall update
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #200 tck = 1'b1;
      #199 o = tdo;
      #1 tck = 1'b0;
   endtask
   task automatic idle;
      logic o;
      repeat (5) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
   // idle to idle scan; data in held high outside the shift
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
         output logic [31:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b1, o);
      if (ir) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
endmodule
`default_nettype wire

/* File: tap_port_tb.sv */
// self-checking bench for the reduced test port with a scan host
// assumes tap_map.vh on the include path; ce stays high throughout
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"
module tap_port_tb;
   logic clk_sys, rst, port_enable, tck, tms, tdi, tdo_out, tdo_oe, trq;
   logic [3:0] user_out, user_oe, user_in, pin_out, buried_q, buried_d, ir_q;
   logic [3:0] pin_oe;
   logic [31:0] got;
   int errors = 0;
   int n_checks = 0;
   tap_port u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .port_enable(port_enable), .tck_pin(tck), .tms_pin(tms),
      .tdi_pin(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
      .user_out(user_out), .user_oe(user_oe), .user_in(user_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .buried_q(buried_q),
      .buried_d(buried_d), .ir_q(ir_q), .test_reset_q(trq));
   tap_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
      .tdo_oe(tdo_oe));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] a, input logic [31:0] e);
      n_checks++;
      if (a !== e) begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, a, e);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_id;
      u_host.scan(1'b0, 32, 32'h0, got);
      check(got, `ID_VALUE);
      check(tdo_oe, 1'b0);
      $display("ident test done");
   endtask
   // each code in turn; unknown codes must fall back to the bypass bit
   task automatic t_codes;
      logic [3:0] codes [4] = '{4'hf, 4'ha, 4'h0, 4'h1};
      foreach (codes[k]) begin
         u_host.scan(1'b1, 4, {28'h0, codes[k]}, got);
         check(got[3:0], `IR_CAPTURE);
         if (codes[k] == `INSN_BYPASS) check(ir_q, `INSN_BYPASS);
         u_host.scan(1'b0, 32, 32'h0000_00b5, got);
         if (codes[k] == `INSN_IDENT) check(got, `ID_VALUE);
         else check(got[8:0], {8'hb5, 1'b0});
      end
      $display("code test done");
   endtask
   task automatic t_pins;
      @(posedge clk_sys) #1 buried_d = 4'h9;
      user_out = 4'h5;
      repeat (3) @(posedge clk_sys);
      check(buried_q, 4'h9);
      check(pin_out, 4'h0);
      check(pin_oe, 4'h0);
      @(posedge clk_sys) #1 port_enable = 1'b0;
      repeat (4) @(posedge clk_sys);
      check(pin_out, 4'h5);
      check(pin_oe, 4'h3);
      check(tdo_oe, 1'b0);
      check(user_in, {1'b0, tdi, tms, tck});
      $display("pin test done");
   endtask
   initial begin
      rst = 1'b1;
      port_enable = 1'b1;
      user_out = 4'h0;
      user_oe = 4'h3;
      buried_d = 4'h0;
      repeat (2) @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check(ir_q, `INSN_RESET);
      check(trq, 1'b1);
      u_host.idle;
      t_id;
      t_codes;
      t_pins;
      complete_run;
   end
   initial begin
      #500000;
      errors++;
      complete_run;
   end
endmodule
bind tap_port tap_port_sva u_sva (.*);
`default_nettype wire
